// ===== hw/card_status_defs.svh
// Offsets, field positions, reset values for the card status block.
// Assumes inclusion by the top module, the property module and the bench.
`ifndef CARD_STATUS_DEFS_SVH
`define CARD_STATUS_DEFS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define REG_STATUS_OFF   12'h000
`define REG_EVENT_OFF    12'h004
`define REG_MASK_OFF     12'h008
`define REG_MODE_OFF     12'h00c

// ----------------------------------------
// Field positions, per socket byte
// ----------------------------------------
`define SOCK_B_SHIFT     8
`define FLD_INSERTED     0
`define FLD_BAT_GOOD     1
`define FLD_BAT_WEAK     2
`define FLD_BAT_DEAD     3
`define FLD_CARD_STATUS_CHANGE_IN       4
`define FLD_SPEAKER      5
`define EVT_INSERT       0
`define EVT_BAT          1
`define EVT_CARD_STATUS_CHANGE_IN       2
`define MODE_IO          0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define EVENT_RST        32'h0000_0000
`define MASK_RST         32'h0000_0000
`define MODE_RST         32'h0000_0000

// ----------------------------------------
// Bus responses
// ----------------------------------------
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ===== hw/card_status_pkg.sv
// Types shared by the card status block.
// Assumes card_status_defs.svh sits beside it.
package card_status_pkg;

	typedef enum logic [1:0] {
		BAT_GOOD,
		BAT_WEAK,
		BAT_DEAD
	} bat_state_t;

	// Raw, synchronised socket inputs
	typedef struct packed {
		logic batteryDetectOne;
		logic batteryDetectTwo;
		logic cardDetectOne;
		logic cardDetectTwo;
	} sock_pins_t;

	// Decoded socket view
	typedef struct packed {
		logic       inserted;
		bat_state_t battery;
		logic       statusChange;
		logic       speaker;
	} sock_view_t;

endpackage : card_status_pkg

// ===== hw/pin_sync.sv
// Two-flop synchroniser for a bundle of socket pins.
// Assumes pins are asynchronous to clk.
`timescale 1ns/1ps

module pin_sync
	import card_status_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// Pins
	input  wire sock_pins_t pinIn,
	output sock_pins_t      pinOut
);

	sock_pins_t stage1;
	sock_pins_t next_stage1;
	sock_pins_t next_pinOut;

	// Idle level is high: no card, inputs pulled up
	always_comb begin
		next_stage1 = rstn ? pinIn : '1;
		next_pinOut = rstn ? stage1 : '1;
	end

	always_ff @(posedge clk) begin
		stage1 <= next_stage1;
		pinOut <= next_pinOut;
	end

endmodule : pin_sync

// ===== hw/sock_decode.sv
// Decodes one socket's synchronised status pins.
// Assumes inputs already synchronised; purely combinational.
`timescale 1ns/1ps

module sock_decode
	import card_status_pkg::*;
(
	// Pins and mode
	input  wire sock_pins_t pins,
	input  wire logic       ioMode,
	// Decoded view
	output sock_view_t      view
);

	always_comb begin
		view.inserted = ~pins.cardDetectOne & ~pins.cardDetectTwo;
		if (!pins.batteryDetectOne) begin
			view.battery = BAT_DEAD;
		end else if (!pins.batteryDetectTwo) begin
			view.battery = BAT_WEAK;
		end else begin
			view.battery = BAT_GOOD;
		end
		// Shared pin means status change only in I/O mode
		view.statusChange = ioMode & ~pins.batteryDetectOne;
		// No card means no I/O configuration, so no speaker
		view.speaker = ioMode & view.inserted &
			pins.batteryDetectTwo;
	end

endmodule : sock_decode

// ===== hw/card_status_top.sv
// Contract
// - Both battery detect inputs high decodes as battery good.
// - Detect two low with detect one high decodes as battery weak.
// - Detect one low decodes as battery dead, memory lost.
// - Detect two is speaker only when card and socket in I/O mode.
// - Speaker signals of both sockets merge into one output.
//
// Top of the two-socket card status block with AXI4-Lite registers.
// Assumes one clock, synchronous active-low reset, pins asynchronous.
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "card_status_defs.svh"

module card_status_top
	import card_status_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// Socket A pins
	input  wire logic        aBatteryDetectOne,
	input  wire logic        aBatteryDetectTwo,
	input  wire logic        aCardDetectOne,
	input  wire logic        aCardDetectTwo,
	// Socket B pins
	input  wire logic        bBatteryDetectOne,
	input  wire logic        bBatteryDetectTwo,
	input  wire logic        bCardDetectOne,
	input  wire logic        bCardDetectTwo,
	// Outputs
	output logic             combinedSpeakerOut,
	output logic             irq,
	// AXI4-Lite write address
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic isMapped(input logic [11:0] a);
		return a == `REG_STATUS_OFF || a == `REG_EVENT_OFF ||
			a == `REG_MASK_OFF || a == `REG_MODE_OFF;
	endfunction : isMapped

	function automatic logic [7:0] sockStatus(input sock_view_t v);
		logic [7:0] s;
		s = 8'h00;
		s[`FLD_INSERTED] = v.inserted;
		s[`FLD_BAT_GOOD] = v.battery == BAT_GOOD;
		s[`FLD_BAT_WEAK] = v.battery == BAT_WEAK;
		s[`FLD_BAT_DEAD] = v.battery == BAT_DEAD;
		s[`FLD_CARD_STATUS_CHANGE_IN]   = v.statusChange;
		s[`FLD_SPEAKER]  = v.speaker;
		return s;
	endfunction : sockStatus

	function automatic logic [31:0] byteMask(input logic [3:0] strb);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{strb[i]}};
		end
		return m;
	endfunction : byteMask

	// ----------------------------------------
	// Synchronise and decode both sockets
	// ----------------------------------------
	sock_pins_t rawPins [2];
	sock_pins_t syncPins [2];
	sock_view_t view [2];
	sock_view_t prevView [2];
	sock_view_t next_prevView [2];
	logic [31:0] mode;

	assign rawPins[0] = '{aBatteryDetectOne, aBatteryDetectTwo,
		aCardDetectOne, aCardDetectTwo};
	assign rawPins[1] = '{bBatteryDetectOne, bBatteryDetectTwo,
		bCardDetectOne, bCardDetectTwo};

	// Pins cross into clk here; nothing downstream sees them raw
	for (genvar s = 0; s < 2; s++) begin : gSock
		pin_sync uSync (
			.clk    (clk),
			.rstn   (rstn),
			.pinIn  (rawPins[s]),
			.pinOut (syncPins[s])
		);
		sock_decode uDec (
			.pins   (syncPins[s]),
			.ioMode (mode[`MODE_IO + s*`SOCK_B_SHIFT]),
			.view   (view[s])
		);
	end

	// ----------------------------------------
	// Status, events, mask, interrupt
	// ----------------------------------------
	logic [31:0] status;
	logic [31:0] events;
	logic [31:0] mask;
	logic [31:0] evtHit;
	logic [31:0] evtClr;
	logic [31:0] next_events;
	logic [31:0] next_mask;
	logic [31:0] next_mode;
	logic        next_irq;
	logic        next_speaker;

	always_comb begin
		status = {16'h0000, sockStatus(view[1]), sockStatus(view[0])};
		evtHit = 32'h0000_0000;
		for (int s = 0; s < 2; s++) begin
			evtHit[`EVT_INSERT + s*`SOCK_B_SHIFT] =
				view[s].inserted != prevView[s].inserted;
			evtHit[`EVT_BAT + s*`SOCK_B_SHIFT] =
				view[s].battery != prevView[s].battery;
			// Status change or ring asserts low on the shared pin
			evtHit[`EVT_CARD_STATUS_CHANGE_IN + s*`SOCK_B_SHIFT] =
				view[s].statusChange & ~prevView[s].statusChange;
		end
		// Set beats clear so a coincident event is never lost
		next_events  = (events & ~evtClr) | evtHit;
		next_irq     = |(next_events & next_mask);
		// XOR keeps either card audible; equal tones from both cancel
		next_speaker = view[0].speaker ^ view[1].speaker;
		for (int s = 0; s < 2; s++) begin
			next_prevView[s] = view[s];
		end
	end

	// ----------------------------------------
	// Event, interrupt and speaker registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			events             <= `EVENT_RST;
			irq                <= 1'b0;
			combinedSpeakerOut <= 1'b0;
			// Match the idle synchroniser view: no spurious first event
			prevView[0]        <= '{1'b0, BAT_GOOD, 1'b0, 1'b0};
			prevView[1]        <= '{1'b0, BAT_GOOD, 1'b0, 1'b0};
		end else begin
			events             <= next_events;
			irq                <= next_irq;
			combinedSpeakerOut <= next_speaker;
			prevView[0]        <= next_prevView[0];
			prevView[1]        <= next_prevView[1];
		end
	end

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	logic [11:0] awAddr;
	logic        awHeld;
	logic [31:0] wData;
	logic [3:0]  wStrb;
	logic        wHeld;
	logic [11:0] next_awAddr;
	logic        next_awHeld;
	logic [31:0] next_wData;
	logic [3:0]  next_wStrb;
	logic        next_wHeld;
	logic        next_bvalid;
	logic [1:0]  next_bresp;
	logic        next_awready;
	logic        next_wready;
	logic        next_arready;
	logic        next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0]  next_rresp;
	logic        doWrite;
	logic [31:0] wm;

	always_comb begin
		next_awAddr  = awAddr;
		next_awHeld  = awHeld;
		next_wData   = wData;
		next_wStrb   = wStrb;
		next_wHeld   = wHeld;
		next_bvalid  = s_axi_bvalid;
		next_bresp   = s_axi_bresp;
		next_rvalid  = s_axi_rvalid;
		next_rdata   = s_axi_rdata;
		next_rresp   = s_axi_rresp;
		next_mask    = mask;
		next_mode    = mode;
		evtClr       = 32'h0000_0000;
		doWrite      = 1'b0;
		wm           = byteMask(wStrb);
		if (s_axi_awvalid && s_axi_awready) begin
			next_awAddr = s_axi_awaddr;
			next_awHeld = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_wData = s_axi_wdata;
			next_wStrb = s_axi_wstrb;
			next_wHeld = 1'b1;
		end
		// Commit one cycle after both halves are held
		if (awHeld && wHeld && !s_axi_bvalid) begin
			doWrite     = 1'b1;
			next_awHeld = 1'b0;
			next_wHeld  = 1'b0;
			next_bvalid = 1'b1;
			next_bresp  = isMapped(awAddr) ? `RESP_OKAY : `RESP_SLVERR;
		end
		// Writes to the status word are answered but change nothing
		if (doWrite) begin
			unique case (awAddr)
				`REG_EVENT_OFF: evtClr = wData & wm;
				`REG_MASK_OFF:  next_mask = (mask & ~wm) | (wData & wm);
				`REG_MODE_OFF:  next_mode = (mode & ~wm) | (wData & wm);
				default: ;
			endcase
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		next_awready = !next_awHeld && !next_bvalid;
		next_wready  = !next_wHeld && !next_bvalid;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp  = isMapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
			unique case (s_axi_araddr)
				`REG_STATUS_OFF: next_rdata = status;
				`REG_EVENT_OFF:  next_rdata = events;
				`REG_MASK_OFF:   next_rdata = mask;
				`REG_MODE_OFF:   next_rdata = mode;
				default:         next_rdata = 32'h0000_0000;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		next_arready = !next_rvalid;
	end

	// ----------------------------------------
	// Bus and control registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			awAddr             <= 12'h000;
			awHeld             <= 1'b0;
			wData              <= 32'h0000_0000;
			wStrb              <= 4'h0;
			wHeld              <= 1'b0;
			s_axi_awready      <= 1'b0;
			s_axi_wready       <= 1'b0;
			s_axi_bvalid       <= 1'b0;
			s_axi_bresp        <= `RESP_OKAY;
			s_axi_arready      <= 1'b0;
			s_axi_rvalid       <= 1'b0;
			s_axi_rdata        <= 32'h0000_0000;
			s_axi_rresp        <= `RESP_OKAY;
			mask               <= `MASK_RST;
			mode               <= `MODE_RST;
		end else begin
			awAddr             <= next_awAddr;
			awHeld             <= next_awHeld;
			wData              <= next_wData;
			wStrb              <= next_wStrb;
			wHeld              <= next_wHeld;
			s_axi_awready      <= next_awready;
			s_axi_wready       <= next_wready;
			s_axi_bvalid       <= next_bvalid;
			s_axi_bresp        <= next_bresp;
			s_axi_arready      <= next_arready;
			s_axi_rvalid       <= next_rvalid;
			s_axi_rdata        <= next_rdata;
			s_axi_rresp        <= next_rresp;
			mask               <= next_mask;
			mode               <= next_mode;
		end
	end

endmodule : card_status_top

// ===== verif/card_socket_model.sv
// Behavioural card in one socket, driving its status pins.
// Assumes the bench sets the controls just after a clock edge.
`timescale 1ns/1ps

module card_socket_model (
	// Controls: bat 0 good, 1 weak, 2 dead
	input  wire logic       inserted,
	input  wire logic [1:0] bat,
	input  wire logic       chg,
	// Socket pins
	output logic            bdOne,
	output logic            bdTwo,
	output logic            cdOne,
	output logic            cdTwo
);
	// Empty socket: pull-ups take every line high
	assign cdOne = !inserted;
	assign cdTwo = !inserted;
	// Status change and ring both pull the shared line low
	assign bdOne = !inserted | (bat != 2'h2 && !chg);
	assign bdTwo = !inserted | (bat == 2'h0);
endmodule : card_socket_model

// ===== verif/card_status_properties.sv
// Bus and output checks for the card status block.
// Assumes it is bound to card_status_top.
`timescale 1ns/1ps
`include "card_status_defs.svh"

module card_status_properties (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rstn,
	// Outputs
	input wire logic        combinedSpeakerOut,
	input wire logic        irq,
	// Socket pins
	input wire logic        aBatteryDetectTwo,
	input wire logic        bBatteryDetectTwo,
	// Bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rstn);

	// Both speaker lines low: no socket can contribute a tone
	wire logic bothQuiet = !aBatteryDetectTwo && !bBatteryDetectTwo;

	a_speaker_quiet: assert property (bothQuiet
		|-> ##3 !combinedSpeakerOut) else $error("speaker with lines low");
	a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid lost");
	a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid lost");
	a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("arready during read");
	a_write_busy: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready) else $error("ready in write");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("late read answer");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("late write answer");
	a_rresp_code: assert property (s_axi_rvalid
		|-> s_axi_rresp inside {`RESP_OKAY, `RESP_SLVERR})
		else $error("bad rresp");
	a_error_zero: assert property (s_axi_rvalid
		&& s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 32'h0)
		else $error("error read not zero");

	c_irq: cover property ($rose(irq));
	c_speaker: cover property ($rose(combinedSpeakerOut));
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR);
endmodule : card_status_properties

bind card_status_top card_status_properties card_status_properties_inst (
	.clk, .rstn, .combinedSpeakerOut, .irq, .aBatteryDetectTwo,
	.bBatteryDetectTwo, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready);

// ===== verif/testbench.sv
// Self-checking bench for the two-socket card status block.
// Assumes the design's register map and a 50 MHz clock.
`timescale 1ns/1ps
`include "card_status_defs.svh"

module testbench;
	logic        clk, rstn, combinedSpeakerOut, irq;
	logic        aBatteryDetectOne, aBatteryDetectTwo;
	logic        aCardDetectOne, aCardDetectTwo;
	logic        bBatteryDetectOne, bBatteryDetectTwo;
	logic        bCardDetectOne, bCardDetectTwo;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr, br;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic        insA, insB, chgA, chgB;
	logic [1:0]  batA, batB;
	int          badCount, testsRun;

	card_status_top card_status_top_inst (.*);
	card_socket_model card_socket_model_inst (.inserted(insA), .bat(batA),
		.chg(chgA), .bdOne(aBatteryDetectOne), .bdTwo(aBatteryDetectTwo),
		.cdOne(aCardDetectOne), .cdTwo(aCardDetectTwo));
	card_socket_model card_socket_model_inst_b (.inserted(insB), .bat(batB),
		.chg(chgB), .bdOne(bBatteryDetectOne), .bdTwo(bBatteryDetectTwo),
		.cdOne(bCardDetectOne), .cdTwo(bCardDetectTwo));

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		testsRun++;
		if (g !== e) begin
			badCount++;
			$display("[ERR] t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	task automatic axiWrite(input logic [11:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge clk);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		while (aw || w) begin
			@(posedge clk);
			if (aw && s_axi_awready === 1'b1) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready === 1'b1) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (s_axi_bvalid !== 1'b1);
		br = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axiWrite

	task automatic axiRead(input logic [11:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do @(posedge clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (s_axi_rvalid !== 1'b1);
		{rd, rr} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'b0;
	endtask : axiRead

	task automatic settle();
		repeat (8) @(posedge clk);
	endtask : settle

	task automatic sReset();
		logic [31:0] s;
		axiRead(`REG_EVENT_OFF);
		chk(rd, `EVENT_RST);
		axiRead(`REG_MASK_OFF);
		chk(rd, `MASK_RST);
		axiRead(`REG_MODE_OFF);
		chk(rd, `MODE_RST);
		axiRead(`REG_STATUS_OFF);
		s = rd;
		// Empty sockets: not inserted, battery lines pulled high
		chk(s, 32'h0000_0202);
		axiWrite(`REG_STATUS_OFF, 32'hffff_ffff);
		axiRead(`REG_STATUS_OFF);
		chk(rd, s);
		chk({31'h0, irq}, 32'h0);
	endtask : sReset

	task automatic sBattery();
		insA <= 1'b1;
		for (int b = 0; b < 3; b++) begin
			batA <= b[1:0];
			settle();
			axiRead(`REG_STATUS_OFF);
			chk({28'h0, rd[3:0]}, 32'h1 | (32'h2 << b));
		end
		// Detect one low with detect two high is still dead
		batA <= 2'h0;
		chgA <= 1'b1;
		settle();
		axiRead(`REG_STATUS_OFF);
		chk({28'h0, rd[3:0]}, 32'h9);
		chgA <= 1'b0;
	endtask : sBattery

	task automatic sInsert();
		axiWrite(`REG_MASK_OFF, 32'h100);
		axiWrite(`REG_EVENT_OFF, 32'hffff_ffff);
		chk({31'h0, irq}, 32'h0);
		insB <= 1'b1;
		settle();
		chk({31'h0, irq}, 32'h1);
		axiRead(`REG_STATUS_OFF);
		chk({31'h0, rd[8]}, 32'h1);
		axiWrite(`REG_EVENT_OFF, 32'h100);
		settle();
		chk({31'h0, irq}, 32'h0);
	endtask : sInsert

	task automatic sStatusChange();
		axiWrite(`REG_MODE_OFF, 32'h1);
		axiWrite(`REG_MASK_OFF, 32'h4);
		axiWrite(`REG_EVENT_OFF, 32'hffff_ffff);
		chgA <= 1'b1;
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		settle();
		chk({31'h0, irq}, 32'h1);
		axiRead(`REG_STATUS_OFF);
		chk({31'h0, rd[4]}, 32'h1);
		chgA <= 1'b0;
		// Same path on socket B
		axiWrite(`REG_MODE_OFF, 32'h100);
		axiWrite(`REG_MASK_OFF, 32'h400);
		axiWrite(`REG_EVENT_OFF, 32'hffff_ffff);
		chgB <= 1'b1;
		settle();
		chk({31'h0, irq}, 32'h1);
		axiRead(`REG_STATUS_OFF);
		chk({31'h0, rd[12]}, 32'h1);
		chgB <= 1'b0;
	endtask : sStatusChange

	task automatic sSpeaker();
		logic e;
		for (int i = 0; i < 16; i++) begin
			batA <= i[2] ? 2'h0 : 2'h1;
			batB <= i[3] ? 2'h0 : 2'h1;
			axiWrite(`REG_MODE_OFF, {23'h0, i[1], 7'h0, i[0]});
			settle();
			e = (i[0] & i[2]) ^ (i[1] & i[3]);
			chk({31'h0, combinedSpeakerOut}, {31'h0, e});
		end
		// An empty socket must not sound, even in I/O mode
		insB <= 1'b0;
		batA <= 2'h0;
		axiWrite(`REG_MODE_OFF, 32'h0000_0101);
		settle();
		chk({31'h0, combinedSpeakerOut}, 32'h1);
		insB <= 1'b1;
	endtask : sSpeaker

	task automatic sUnmapped();
		axiRead(12'h010);
		chk({30'h0, rr}, {30'h0, `RESP_SLVERR});
		chk(rd, 32'h0);
		axiWrite(12'h010, 32'h1);
		chk({30'h0, br}, {30'h0, `RESP_SLVERR});
	endtask : sUnmapped

	task automatic conclude();
		$display("Checks %0d, mismatches %0d", testsRun, badCount);
		if (badCount == 0 && testsRun > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Watchdog: the tests need well under 2000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		badCount++;
		conclude();
	end

	initial begin
		{rstn, insA, insB, chgA, chgB, batA, batB} = 9'h000;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
		s_axi_wstrb = 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{badCount, testsRun} = 64'h0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		sReset();
		sBattery();
		sInsert();
		sStatusChange();
		sSpeaker();
		sUnmapped();
		conclude();
	end
endmodule : testbench
